// File: verilog/pin_mux_gpio_rs485_dir.sv
// Pin function select, GPIO and transceiver enable block with AXI4-Lite registers
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module pin_mux_gpio_rs485_dir (
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]             awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   // AXI4-Lite write data
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   // AXI4-Lite write response
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   // AXI4-Lite read address
   input  wire logic [7:0]             araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   // AXI4-Lite read data
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   // UART core side
   input  wire pin_mux_pkg::uart_sig_s uart_i,
   output logic                        cts_n,
   output logic                        dsr_n,
   // Pins
   input  wire logic [9:0]             pin_in,
   output logic [9:0]                  pin_out,
   output logic [9:0]                  pin_oe
);
   logic [3:0]  delay_q;
   logic [9:0]  func_q;
   logic [9:0]  dir_q;
   logic [9:0]  lvl_q;
   logic        aw_ok_q;
   logic        aw_ok_d;
   logic        w_ok_q;
   logic        w_ok_d;
   logic        bvalid_d;
   logic [5:0]  wr_idx_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        do_wr;
   logic        wr_hit;
   logic [15:0] wmask;
   logic [15:0] wnew;
   logic [9:0]  wbits;
   logic [9:0]  gp_mask;
   logic [9:0]  set_gp;
   logic [9:0]  clr_gp;
   logic        en_send;
   logic        en_send_p;
   logic        en_addr_p;
   logic [9:0]  alt;
   logic [9:0]  alt_val;
   logic [9:0]  alt_oe;
   logic [5:0]  rd_idx;
   logic [31:0] rd_data;
   logic        rd_hit;
   pin_mux_pkg::flow_mode_e mode;
   pin_mux_pkg::pin7_mode_e p7_mode;

   // Write channel: address and data are taken in either order
   assign do_wr = aw_ok_q && w_ok_q && !bvalid;

   always_comb begin
      aw_ok_d = aw_ok_q;
      w_ok_d = w_ok_q;
      bvalid_d = bvalid;
      if (awvalid && awready) begin
         aw_ok_d = 1'b1;
      end
      if (wvalid && wready) begin
         w_ok_d = 1'b1;
      end
      if (do_wr) begin
         aw_ok_d = 1'b0;
         w_ok_d = 1'b0;
         bvalid_d = 1'b1;
      end else if (bvalid && bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_q <= 1'b0;
         w_ok_q <= 1'b0;
         bvalid <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bresp <= pin_mux_pkg::RESP_OKAY;
      end else begin
         aw_ok_q <= aw_ok_d;
         w_ok_q <= w_ok_d;
         bvalid <= bvalid_d;
         // Ready only drops after a capture, so one write is in flight
         awready <= !aw_ok_d && !bvalid_d;
         wready <= !w_ok_d && !bvalid_d;
         if (do_wr) begin
            bresp <= wr_hit ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (awvalid && awready) begin
         wr_idx_q <= awaddr[7:2];
      end
      if (wvalid && wready) begin
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      case (wr_idx_q)
         pin_mux_pkg::IDX_DELAY,
         pin_mux_pkg::IDX_FUNC,
         pin_mux_pkg::IDX_DIR,
         pin_mux_pkg::IDX_SET,
         pin_mux_pkg::IDX_CLR,
         pin_mux_pkg::IDX_STATUS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Only the two low byte lanes carry register bits
   assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wnew = wdata_q[15:0] & wmask;
   assign wbits = wnew[9:0];

   // Register file; upper bits are not stored and read as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         delay_q <= pin_mux_pkg::DELAY_RST;
         func_q <= pin_mux_pkg::FUNC_RST;
         dir_q <= pin_mux_pkg::DIR_RST;
      end else if (do_wr) begin
         if (wr_idx_q == pin_mux_pkg::IDX_DELAY) begin
            delay_q <= (delay_q & ~wmask[3:0]) | wnew[3:0];
         end
         if (wr_idx_q == pin_mux_pkg::IDX_FUNC) begin
            func_q <= (func_q & ~wmask[9:0]) | wbits;
         end
         if (wr_idx_q == pin_mux_pkg::IDX_DIR) begin
            dir_q <= (dir_q & ~wmask[9:0]) | wbits;
         end
      end
   end

   // Set and clear reach only GPIO pins that are outputs
   assign gp_mask = dir_q & ~alt;
   assign set_gp = (do_wr && wr_idx_q == pin_mux_pkg::IDX_SET) ? (wbits & gp_mask) : 10'h000;
   assign clr_gp = (do_wr && wr_idx_q == pin_mux_pkg::IDX_CLR) ? (wbits & gp_mask) : 10'h000;

   // Level survives direction changes; nothing else touches it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_q <= pin_mux_pkg::LVL_RST;
      end else begin
         lvl_q <= (lvl_q | set_gp) & ~clr_gp;
      end
   end

   xcvr_turnaround u_turn (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .tx_active (uart_i.tx_active),
      .bit_tick  (uart_i.bit_tick),
      .delay     (delay_q),
      .en_q      (en_send)
   );

   assign en_send_p = func_q[pin_mux_pkg::FS_POL] ? en_send : !en_send;
   assign en_addr_p = func_q[pin_mux_pkg::FS_POL] ? uart_i.addr_match : !uart_i.addr_match;
   assign mode = pin_mux_pkg::flow_mode_e'(func_q[pin_mux_pkg::FS_MODE_HI:0]);
   assign p7_mode = pin_mux_pkg::pin7_mode_e'(func_q[pin_mux_pkg::FS_P7_HI:pin_mux_pkg::FS_P7_LO]);

   // Alternate function map; reserved codes leave pins as GPIO
   always_comb begin
      alt = 10'h000;
      alt_val = 10'h000;
      alt_oe = 10'h000;
      case (mode)
         pin_mux_pkg::FLOW_RTS_CTS: begin
            alt[pin_mux_pkg::PIN_CTS] = 1'b1;
            alt[pin_mux_pkg::PIN_RTS] = 1'b1;
            alt_oe[pin_mux_pkg::PIN_RTS] = 1'b1;
            alt_val[pin_mux_pkg::PIN_RTS] = uart_i.rts_n;
         end
         pin_mux_pkg::FLOW_DTR_DSR: begin
            alt[pin_mux_pkg::PIN_DSR] = 1'b1;
            alt[pin_mux_pkg::PIN_DTR] = 1'b1;
            alt_oe[pin_mux_pkg::PIN_DTR] = 1'b1;
            alt_val[pin_mux_pkg::PIN_DTR] = uart_i.dtr_n;
         end
         pin_mux_pkg::FLOW_EN_SEND: begin
            alt[pin_mux_pkg::PIN_RTS] = 1'b1;
            alt_oe[pin_mux_pkg::PIN_RTS] = 1'b1;
            alt_val[pin_mux_pkg::PIN_RTS] = en_send_p;
         end
         pin_mux_pkg::FLOW_EN_ADDR: begin
            alt[pin_mux_pkg::PIN_RTS] = 1'b1;
            alt_oe[pin_mux_pkg::PIN_RTS] = 1'b1;
            alt_val[pin_mux_pkg::PIN_RTS] = en_addr_p;
         end
         default: begin
         end
      endcase
      if (func_q[pin_mux_pkg::FS_PIN7]) begin
         case (p7_mode)
            pin_mux_pkg::P7_EN_SEND: begin
               alt[pin_mux_pkg::PIN_EN7] = 1'b1;
               alt_oe[pin_mux_pkg::PIN_EN7] = 1'b1;
               alt_val[pin_mux_pkg::PIN_EN7] = en_send_p;
            end
            pin_mux_pkg::P7_EN_ADDR: begin
               alt[pin_mux_pkg::PIN_EN7] = 1'b1;
               alt_oe[pin_mux_pkg::PIN_EN7] = 1'b1;
               alt_val[pin_mux_pkg::PIN_EN7] = en_addr_p;
            end
            default: begin
            end
         endcase
      end
      if (func_q[pin_mux_pkg::FS_CLK]) begin
         alt[pin_mux_pkg::PIN_CLK] = 1'b1;
         alt_oe[pin_mux_pkg::PIN_CLK] = 1'b1;
         alt_val[pin_mux_pkg::PIN_CLK] = uart_i.clk_out;
      end
      if (func_q[pin_mux_pkg::FS_TX_TOG]) begin
         alt[pin_mux_pkg::PIN_TXT] = 1'b1;
         alt_oe[pin_mux_pkg::PIN_TXT] = 1'b1;
         alt_val[pin_mux_pkg::PIN_TXT] = uart_i.tx_toggle;
      end
      if (func_q[pin_mux_pkg::FS_RX_TOG]) begin
         alt[pin_mux_pkg::PIN_RXT] = 1'b1;
         alt_oe[pin_mux_pkg::PIN_RXT] = 1'b1;
         alt_val[pin_mux_pkg::PIN_RXT] = uart_i.rx_toggle;
      end
   end

   // Pin drivers; alternate functions override direction and level
   for (genvar i = 0; i < pin_mux_pkg::NPIN; i++) begin : g_pin
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pin_oe[i] <= 1'b0;
            pin_out[i] <= 1'b0;
         end else begin
            pin_oe[i] <= alt[i] ? alt_oe[i] : dir_q[i];
            pin_out[i] <= alt[i] ? alt_val[i] : lvl_q[i];
         end
      end
   end

   // Flow inputs idle deasserted when their pins are GPIO
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cts_n <= 1'b1;
         dsr_n <= 1'b1;
      end else begin
         cts_n <= alt[pin_mux_pkg::PIN_CTS] ? pin_in[pin_mux_pkg::PIN_CTS] : 1'b1;
         dsr_n <= alt[pin_mux_pkg::PIN_DSR] ? pin_in[pin_mux_pkg::PIN_DSR] : 1'b1;
      end
   end

   // Read channel; write-only registers read as zero
   assign rd_idx = araddr[7:2];

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      case (rd_idx)
         pin_mux_pkg::IDX_DELAY: rd_data[3:0] = delay_q;
         pin_mux_pkg::IDX_FUNC: rd_data[9:0] = func_q;
         pin_mux_pkg::IDX_DIR: rd_data[9:0] = dir_q;
         pin_mux_pkg::IDX_SET,
         pin_mux_pkg::IDX_CLR: rd_hit = 1'b1;
         pin_mux_pkg::IDX_STATUS: begin
            rd_data[9:0] = lvl_q;
            rd_data[pin_mux_pkg::ST_EN] = en_send;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= pin_mux_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_data;
         rresp <= rd_hit ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   a_rx_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
      func_q[9] |=> pin_oe[9] && pin_out[9] == $past(uart_i.rx_toggle))
      else $error("pin 9 not carrying receive toggle");
   a_tx_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
      func_q[8] |=> pin_oe[8] && pin_out[8] == $past(uart_i.tx_toggle))
      else $error("pin 8 not carrying transmit toggle");
   a_clk_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      func_q[7] |=> pin_oe[6] && pin_out[6] == $past(uart_i.clk_out))
      else $error("pin 6 not carrying clock");
   a_pin7_gpio: assert property (@(posedge aclk) disable iff (!aresetn)
      !func_q[4] |=> pin_oe[7] == $past(dir_q[7]) && pin_out[7] == $past(lvl_q[7]))
      else $error("pin 7 not GPIO with pin select clear");
   a_pin7_addr: assert property (@(posedge aclk) disable iff (!aresetn)
      func_q[6:4] == 3'h5 |=> pin_out[7] == $past(en_addr_p) && pin_oe[7])
      else $error("pin 7 not carrying address match enable");
   a_pin5_send: assert property (@(posedge aclk) disable iff (!aresetn)
      func_q[3:0] == 4'hB |=> pin_out[5] == $past(en_send))
      else $error("pin 5 send enable wrong polarity");
   a_rts_cts: assert property (@(posedge aclk) disable iff (!aresetn)
      func_q[2:0] == 3'h1 |=> !pin_oe[4] && pin_oe[5])
      else $error("flow pins wrong direction");
   a_gpio_dir: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> pin_oe[0] == $past(dir_q[0]))
      else $error("pin 0 direction not following register");
   a_set_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      set_gp != 10'h000 |=> (lvl_q & $past(set_gp)) == $past(set_gp))
      else $error("set did not raise output");
   a_clr_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_gp != 10'h000 |=> (lvl_q & $past(clr_gp)) == 10'h000)
      else $error("clear did not lower output");
   a_set_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      do_wr |=> ((lvl_q ^ $past(lvl_q)) & ~$past(gp_mask)) == 10'h000)
      else $error("set or clear touched an input or alternate pin");
   a_lvl_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !do_wr |=> $stable(lvl_q))
      else $error("output level changed without a write");
endmodule : pin_mux_gpio_rs485_dir
`default_nettype wire

// File: verilog/pin_mux_pkg.sv
// Constants, types and field layout of the pin function and GPIO block
package pin_mux_pkg;
   localparam int NPIN = 10;
   localparam int DLY_W = 4;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_DELAY = 6'h0B;
   localparam logic [5:0] IDX_FUNC = 6'h0C;
   localparam logic [5:0] IDX_DIR = 6'h0D;
   localparam logic [5:0] IDX_SET = 6'h0E;
   localparam logic [5:0] IDX_CLR = 6'h0F;
   localparam logic [5:0] IDX_STATUS = 6'h1F;
   // Function select fields and status enable bit
   localparam int FS_RX_TOG = 9;
   localparam int FS_TX_TOG = 8;
   localparam int FS_CLK = 7;
   localparam int FS_P7_HI = 6;
   localparam int FS_P7_LO = 5;
   localparam int FS_PIN7 = 4;
   localparam int FS_POL = 3;
   localparam int FS_MODE_HI = 2;
   localparam int ST_EN = 10;
   // Pin numbers of the alternate functions
   localparam int PIN_DTR = 2;
   localparam int PIN_DSR = 3;
   localparam int PIN_CTS = 4;
   localparam int PIN_RTS = 5;
   localparam int PIN_CLK = 6;
   localparam int PIN_EN7 = 7;
   localparam int PIN_TXT = 8;
   localparam int PIN_RXT = 9;
   // Reset values and response codes
   localparam logic [9:0] FUNC_RST = 10'h300;
   localparam logic [9:0] DIR_RST = 10'h000;
   localparam logic [9:0] LVL_RST = 10'h000;
   localparam logic [3:0] DELAY_RST = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      FLOW_GPIO    = 3'h0,
      FLOW_RTS_CTS = 3'h1,
      FLOW_DTR_DSR = 3'h2,
      FLOW_EN_SEND = 3'h3,
      FLOW_EN_ADDR = 3'h4
   } flow_mode_e;
   typedef enum logic [1:0] {
      P7_GPIO    = 2'h0,
      P7_EN_SEND = 2'h1,
      P7_EN_ADDR = 2'h2
   } pin7_mode_e;
   // Signals from the UART core
   typedef struct packed {
      logic tx_active;
      logic bit_tick;
      logic addr_match;
      logic tx_toggle;
      logic rx_toggle;
      logic clk_out;
      logic rts_n;
      logic dtr_n;
   } uart_sig_s;
endpackage : pin_mux_pkg

// File: verilog/xcvr_turnaround.sv
// Transmit-active transceiver enable with turnaround hold
`timescale 1ns/1ns
`default_nettype none
module xcvr_turnaround (
   // Clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // UART timing
   input  wire logic                         tx_active,
   input  wire logic                         bit_tick,
   input  wire logic [pin_mux_pkg::DLY_W-1:0] delay,
   // Enable, true while sending or holding
   output logic                              en_q
);
   logic [pin_mux_pkg::DLY_W-1:0] cnt_q;

   // tx_active covers the stop bit, so the hold starts after it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= 1'b0;
         cnt_q <= pin_mux_pkg::DELAY_RST;
      end else if (tx_active) begin
         en_q <= 1'b1;
         cnt_q <= delay;
      end else if (en_q) begin
         if (cnt_q == '0) begin
            en_q <= 1'b0;
         end else if (bit_tick) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end

   a_en_on_send: assert property (@(posedge aclk) disable iff (!aresetn)
      tx_active |=> en_q)
      else $error("enable not raised while sending");
   a_hold_after: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(tx_active) && delay != 4'h0 |-> en_q ##1 en_q)
      else $error("enable dropped before turnaround");
   a_drop_at_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !tx_active && en_q && cnt_q == 4'h0 |=> !en_q)
      else $error("enable not dropped at end of turnaround");
   a_count_tick: assert property (@(posedge aclk) disable iff (!aresetn)
      !tx_active && en_q && !bit_tick |=> cnt_q == $past(cnt_q))
      else $error("turnaround count moved without a bit tick");
endmodule : xcvr_turnaround
`default_nettype wire

// File: tb/pin_partner.sv
// Peripherals and transceiver seen at the ten multi-function pins
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
   // Device pins
   input  wire logic [9:0] pin_out,
   input  wire logic [9:0] pin_oe,
   // Levels the peripherals drive onto released pins
   input  wire logic [9:0] ext_lvl,
   output logic      [9:0] pin_in
);
   // A driven pin reads back its own level, a released one shows the peripheral
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
      end
   end
endmodule : pin_partner
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the pin function, GPIO and transceiver enable block
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam logic [7:0] A_DLY = {pin_mux_pkg::IDX_DELAY, 2'b00};
   localparam logic [7:0] A_FNC = {pin_mux_pkg::IDX_FUNC, 2'b00};
   localparam logic [7:0] A_DIR = {pin_mux_pkg::IDX_DIR, 2'b00};
   localparam logic [7:0] A_SET = {pin_mux_pkg::IDX_SET, 2'b00};
   localparam logic [7:0] A_CLR = {pin_mux_pkg::IDX_CLR, 2'b00};
   localparam logic [1:0] OK = pin_mux_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = pin_mux_pkg::RESP_SLVERR;
   logic                   aclk, aresetn;
   logic [7:0]             awaddr, araddr;
   logic                   awvalid, awready, wvalid, wready, bvalid, bready;
   logic                   arvalid, arready, rvalid, rready;
   logic [31:0]            wdata, rdata;
   logic [3:0]             wstrb;
   logic [1:0]             bresp, rresp;
   pin_mux_pkg::uart_sig_s uart_i;
   logic                   cts_n, dsr_n;
   logic [9:0]             pin_in, pin_out, pin_oe, ext_lvl, dv, rv;
   logic [17:0]            e;
   logic [17:0]            exp_q[$];
   int                     fail_count, check_count;
   // Alternate-function table: select value, expected drive, level, cts_n, dsr_n
   logic [9:0]             t_fn[7] = '{10'h380, 10'h001, 10'h002, 10'h004, 10'h050, 10'h040, 10'h000};
   logic [9:0]             t_oe[7] = '{10'h3FF, 10'h3EF, 10'h3F7, 10'h3FF, 10'h3FF, 10'h3FF, 10'h3FF};
   logic [9:0]             t_lv[7] = '{10'h2BF, 10'h3DF, 10'h3FB, 10'h3DF, 10'h37F, 10'h3FF, 10'h3FF};
   logic [1:0]             t_hs[7] = '{2'h3, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};

   pin_mux_gpio_rs485_dir pin_mux_gpio_rs485_dir_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .uart_i(uart_i), .cts_n(cts_n), .dsr_n(dsr_n),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   pin_partner pin_partner_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic hang();
      fail_count++;
      wrap_up();
   endtask : hang

   // Address and data offered together, each released at its own handshake;
   // bready stays up between writes so back-to-back calls never drive it twice in one step
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      logic done;
      aw = 1'b1;
      w = 1'b1;
      done = 1'b0;
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            done = 1'b1;
            cmp({30'h0, bresp}, {30'h0, er});
         end
      end
      if (!done) hang();
   endtask : wr

   // Expected answer is queued; the monitor below compares it; rready stays up between reads
   task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      logic ar;
      logic done;
      ar = 1'b1;
      done = 1'b0;
      exp_q.push_back({er, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (ar && arready === 1'b1) begin
            ar = 1'b0;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            done = 1'b1;
         end
      end
      if (!done) hang();
   endtask : rd

   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         // An unexpected answer meets a response code the block never gives
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3_FFFF;
         cmp(rdata, {16'h0000, e[15:0]});
         cmp({30'h0, rresp}, {30'h0, e[17:16]});
      end
   end

   // Pins follow a register write one edge after it lands
   task automatic pins(input logic [9:0] oe, input logic [9:0] lv);
      repeat (2) @(posedge aclk);
      cmp({22'h0, pin_oe}, {22'h0, oe});
      cmp({22'h0, pin_out & pin_oe}, {22'h0, lv & oe});
   endtask : pins

   task automatic turn(input logic [15:0] fn, input int p, input logic [3:0] d, input logic on);
      wr(A_FNC, fn, OK);
      wr(A_DLY, {12'h000, d}, OK);
      uart_i.tx_active <= 1'b1;
      repeat (4) @(posedge aclk);
      cmp({31'h0, pin_out[p]}, {31'h0, on});
      uart_i.tx_active <= 1'b0;
      for (int k = 0; k < d; k++) begin
         repeat (7) @(posedge aclk);
         cmp({31'h0, pin_out[p]}, {31'h0, on});
         uart_i.bit_tick <= 1'b1;
         @(posedge aclk);
         uart_i.bit_tick <= 1'b0;
      end
      repeat (5) @(posedge aclk);
      cmp({31'h0, pin_out[p]}, {31'h0, ~on});
   endtask : turn

   initial begin
      fail_count = 0;
      check_count = 0;
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      uart_i = '{tx_active: 1'b0, bit_tick: 1'b0, addr_match: 1'b1, tx_toggle: 1'b0,
                 rx_toggle: 1'b1, clk_out: 1'b0, rts_n: 1'b0, dtr_n: 1'b0};
      ext_lvl = 10'h000;
      void'($urandom(32'hf284_5c11));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      pins(10'h300, 10'h200);
      rd(A_DLY, 16'h0000, OK);
      rd(A_FNC, 16'h0300, OK);
      rd(A_DIR, 16'h0000, OK);
      rd(A_SET, 16'h0000, OK);
      rd(A_CLR, 16'h0000, OK);
      rd(8'h40, 16'h0000, ERR);
      wr(8'h40, 16'h03FF, ERR);
      // Random direction and clear masks over plain GPIO
      wr(A_FNC, 16'h0000, OK);
      dv = 10'($urandom);
      rv = 10'($urandom);
      wr(A_DIR, {6'h00, dv}, OK);
      rd(A_DIR, {6'h00, dv}, OK);
      wr(A_SET, 16'h03FF, OK);
      pins(dv, dv);
      wr(A_DIR, 16'h03FF, OK);
      pins(10'h3FF, dv);
      wr(A_CLR, {6'h00, rv}, OK);
      wr(A_SET, 16'h0000, OK);
      pins(10'h3FF, dv & ~rv);
      wr(A_DIR, 16'h0000, OK);
      wr(A_DIR, 16'h03FF, OK);
      pins(10'h3FF, dv & ~rv);
      wr(A_SET, 16'h03FF, OK);
      // Second pass lifts the released flow inputs, so cts_n and dsr_n are expected high in every table row
      for (int i = 0; i < 14; i++) begin
         ext_lvl <= (i < 7) ? 10'h000 : (10'($urandom) | 10'h018);
         wr(A_FNC, {6'h00, t_fn[i % 7]}, OK);
         pins(t_oe[i % 7], t_lv[i % 7]);
         cmp({30'h0, cts_n, dsr_n}, {30'h0, t_hs[i % 7] | {ext_lvl[4], ext_lvl[3]}});
      end
      rd({pin_mux_pkg::IDX_STATUS, 2'b00}, 16'h03FF, OK);
      turn(16'h000B, 5, 4'($urandom), 1'b1);
      turn(16'h000B, 5, 4'h0, 1'b1);
      turn(16'h0030, 7, 4'hF, 1'b0);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
